// file: dv/acrc_host_model.sv
// Host controller model that drives the APB port of the calibration back end.
// Assumes the bench calls its transfer task and keeps the calibration copy itself.
`timescale 1ns/1ns
module acrc_host_model (
  // Clock
  input  wire logic        sys_clk,
  // APB answer
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  // APB request
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [7:0]  paddr,
  output      logic [31:0] pwdata
);
  // ****************************************
  // Transfer
  // ****************************************
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // One transfer: setup, then access held until pready is seen high or 16 cycles pass.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic tmo);
    tmo = 1'b1;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && tmo; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) tmo = 1'b0;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle data lines show the inverse so stale values are never mistaken.
    pwdata  <= ~wd;
  endtask
endmodule // acrc_host_model

// file: dv/adc_channel_calibration_regcheck_test.sv
// Self-checking bench of the calibration and register-check back end.
// Assumes the host model drives APB and the bench drives the filter outputs.
`timescale 1ns/1ns
module adc_channel_calibration_regcheck_test;
  logic             sys_clk;
  logic             rst;
  logic             psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata;
  logic [2:0][23:0] raw_sample;
  logic             conversion_ready_n, mod_tick, temp_route, external, chop_enable;
  logic [31:0]      regs_s [0:15];
  logic [31:0]      v;
  int               num_errors;
  int               check_count;

  acrc_top dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_sample(raw_sample), .conversion_ready_n(conversion_ready_n),
    .third_channel_mod_tick(mod_tick), .third_channel_temp_route(temp_route),
    .third_channel_external(external), .chop_enable(chop_enable));
  acrc_host_model host_u (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic exp_err);
    logic err, tmo;
    host_u.xfer(wr, a, d, v, err, tmo);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    if (tmo) begin
      num_errors++;
      report_and_stop();
    end
    if (wr && !exp_err) regs_s[a[5:2]] = d;
  endtask

  // Waits for two ready falls so the results carry the current inputs.
  task automatic fresh();
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; conversion_ready_n !== 1'b0; n++) begin
        @(posedge sys_clk);
        if (n > 400) chk("ready_timeout", 0, 1);
        if (n > 400) report_and_stop();
      end
      bus(0, acrc_pkg::ADDR_RESULT0, 0, 0);
    end
  endtask

  function automatic logic [15:0] exp_crc(input logic poly);
    logic [182:0] b;
    logic [15:0]  c;
    b = {regs_s[1][1:0], regs_s[2][6:0], regs_s[5][9:0], regs_s[4][9:0], regs_s[3][9:0],
         regs_s[8][23:0], regs_s[7][23:0], regs_s[6][23:0],
         regs_s[11][23:0], regs_s[10][23:0], regs_s[9][23:0]};
    c = acrc_pkg::CRC_SEED;
    for (int i = 182; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ?
          (poly ? acrc_pkg::CRC_POLY_ANSI : acrc_pkg::CRC_POLY_CCITT) : 16'h0000);
    return c;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    bus(0, acrc_pkg::ADDR_CONFIG, 0, 0);
    chk("config_reset", 32'h00000004, v);
    bus(0, acrc_pkg::ADDR_OFFSET0, 0, 0);
    chk("offset_reset", 32'h00000000, v);
    bus(0, acrc_pkg::ADDR_GAIN0 + 8'h08, 0, 0);
    chk("gain_reset", 32'h00800000, v);
    bus(1, acrc_pkg::ADDR_REGCHECK, 32'h0000abcd, 0);
    bus(0, acrc_pkg::ADDR_REGCHECK, 0, 0);
    chk("regcheck_ro", 32'h00000000, v);
    bus(0, 8'hfc, 0, 1);
    chk("unmapped_data", 32'h00000000, v);
    bus(1, acrc_pkg::ADDR_PHASE0, 32'h00000264, 0);
    bus(0, acrc_pkg::ADDR_PHASE0, 0, 0);
    chk("phase_bits", 32'h00000264, v);
    bus(1, acrc_pkg::ADDR_PHASE0, 32'h00000000, 0);
  endtask

  task automatic t_calib();
    raw_sample <= {24'h7fffff, 24'hfff000, 24'h000100};
    bus(1, acrc_pkg::ADDR_CONFIG, 32'h00000000, 0);
    bus(1, acrc_pkg::ADDR_PHASE0 + 8'h04, 32'h00000200, 0);
    fresh();
    bus(0, acrc_pkg::ADDR_RESULT0 + 8'h04, 0, 0);
    chk("identity_ch1", 32'h00fff000, v);
    // The host rewrites every coefficient except the channel 1 gain, which keeps its reset value.
    bus(1, acrc_pkg::ADDR_OFFSET0, 32'h00000010, 0);
    bus(1, acrc_pkg::ADDR_GAIN0, 32'h00400000, 0);
    bus(1, acrc_pkg::ADDR_OFFSET0 + 8'h04, 32'h00ffff00, 0);
    bus(1, acrc_pkg::ADDR_OFFSET0 + 8'h08, 32'h00ffffff, 0);
    bus(1, acrc_pkg::ADDR_GAIN0 + 8'h08, 32'h00ffffff, 0);
    fresh();
    bus(0, acrc_pkg::ADDR_RESULT0, 0, 0);
    chk("result_ch0", 32'h00000078, v);
    bus(0, acrc_pkg::ADDR_RESULT0 + 8'h04, 0, 0);
    chk("result_ch1", 32'h00fff100, v);
    bus(0, acrc_pkg::ADDR_RESULT0 + 8'h08, 0, 0);
    chk("result_ch2", 32'h007fffff, v);
  endtask

  task automatic t_crc(input logic poly, input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d, 0);
    for (int n = 0; n < 200 && v[15:0] !== exp_crc(poly); n++)
      bus(0, acrc_pkg::ADDR_REGCHECK, 0, 0);
    chk("regcheck", {16'h0, exp_crc(poly)}, v);
    bus(0, poly ? acrc_pkg::ADDR_NULL_RESP : acrc_pkg::ADDR_STATUS, 0, 0);
    chk("changed_set", 32'h1, {31'h0, v[0]});
    bus(0, acrc_pkg::ADDR_STATUS, 0, 0);
    chk("changed_clear", 32'h0, {31'h0, v[0]});
  endtask

  task automatic t_temp();
    int n;
    bus(1, acrc_pkg::ADDR_CONFIG, 32'h00000010, 0);
    repeat (3) @(posedge sys_clk);
    chk("route_int", 32'h1, {30'h0, external, temp_route});
    for (n = 0; n < 40 && mod_tick !== 1'b1; n++) @(posedge sys_clk);
    @(posedge sys_clk);
    for (n = 1; n < 40 && mod_tick !== 1'b1; n++) @(posedge sys_clk);
    chk("tick_gap", 32, n);
    v = 0;
    for (n = 0; n < 1200 && v[1] !== 1'b1; n++) bus(0, acrc_pkg::ADDR_STATUS, 0, 0);
    chk("third_new", 32'h1, {31'h0, v[1]});
    bus(1, acrc_pkg::ADDR_CONFIG, 32'h00000030, 0);
    repeat (3) @(posedge sys_clk);
    chk("route_ext", 32'h2, {30'h0, external, temp_route});
    bus(1, acrc_pkg::ADDR_CONFIG, 32'h00000040, 0);
    repeat (3) @(posedge sys_clk);
    chk("chop_tick", 32'h3, {30'h0, chop_enable, mod_tick});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    raw_sample = '0;
    foreach (regs_s[i]) regs_s[i] = 32'h00000000;
    regs_s[2] = 32'h00000004;
    for (int i = 9; i < 12; i++) regs_s[i] = 32'h00800000;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_calib();
    t_crc(1'b0, acrc_pkg::ADDR_MODE, 32'h00000001);
    t_crc(1'b0, acrc_pkg::ADDR_PHASE0 + 8'h08, 32'h000003e0);
    t_crc(1'b1, acrc_pkg::ADDR_MODE, 32'h00000003);
    t_temp();
    report_and_stop();
  end
endmodule // adc_channel_calibration_regcheck_test

// file: src/acrc_calib.sv
// Offset subtraction and gain scaling of one channel, one cycle of latency.
// Assumes samples and coefficients on the system clock.
`timescale 1ns/1ns
module acrc_calib (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Coefficients
  input  wire logic [23:0]              offset_coefficient,
  input  wire logic [23:0]              gain_coefficient,
  // Samples
  input  wire acrc_pkg::acrc_sample_type in_sample,
  output      acrc_pkg::acrc_sample_type out_q
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [26:0] scaled;
  logic        [23:0] sat;

  assign diff   = $signed({in_sample.data[23], in_sample.data})
                - $signed({offset_coefficient[23], offset_coefficient});
  assign prod   = 50'(diff * $signed({1'b0, gain_coefficient}));
  assign scaled = prod[49:23];
  assign sat    = (scaled > 27'sh07fffff) ? 24'h7fffff :
                  (scaled < -27'sh0800000) ? 24'h800000 : scaled[23:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q.valid <= in_sample.valid;
      out_q.data  <= sat;
    end
  end
endmodule // acrc_calib

// file: src/acrc_pkg.sv
// Constants, types and helper functions of the calibration and register-check back end.
// Assumes a single 10 MHz system clock that also serves as the modulator clock.
package acrc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h04;
  localparam logic [7:0] ADDR_CONFIG    = 8'h08;
  localparam logic [7:0] ADDR_PHASE0    = 8'h0c;
  localparam logic [7:0] ADDR_OFFSET0   = 8'h18;
  localparam logic [7:0] ADDR_GAIN0     = 8'h24;
  localparam logic [7:0] ADDR_REGCHECK  = 8'h30;
  localparam logic [7:0] ADDR_NULL_RESP = 8'h34;
  localparam logic [7:0] ADDR_RESULT0   = 8'h38;
  localparam logic [7:0] ADDR_STEP      = 8'h04;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int STATUS_REGMAP_BIT    = 0;
  localparam int STATUS_THIRD_NEW_BIT = 1;
  localparam int STATUS_READY_BIT     = 2;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [6:0]  CONFIG_RESET   = 7'h04;
  localparam logic [9:0]  PHASE_RESET    = 10'h000;
  localparam logic [23:0] OFFSET_RESET   = 24'h000000;
  localparam logic [23:0] GAIN_RESET     = 24'h800000;
  localparam logic [15:0] REGCHECK_RESET = 16'h0000;
  localparam logic [15:0] CRC_SEED       = 16'hffff;
  localparam logic [15:0] CRC_POLY_CCITT = 16'h1021;
  localparam logic [15:0] CRC_POLY_ANSI  = 16'h8005;
  localparam logic [3:0]  OSR_CODE_MAX   = 4'h8;
  localparam logic [3:0]  PHASE_CODE_MAX = 4'h4;
  localparam logic [4:0]  TEMP_LAST      = 5'h1f;
  localparam int          REGCHECK_BITS  = 183;

  typedef struct packed {
    logic       chop;
    logic       temp_sel;
    logic       temp_en;
    logic [3:0] osr_code;
  } acrc_config_type;

  typedef struct packed {
    logic crc_type;
    logic regcheck_en;
  } acrc_mode_type;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } acrc_sample_type;

  // Modulator cycles per conversion, minus one.
  function automatic logic [13:0] osr_mask(input logic [3:0] code);
    logic [3:0] c;
    c = (code > OSR_CODE_MAX) ? OSR_CODE_MAX : code;
    return 14'((15'h0040 << c) - 15'h0001);
  endfunction

  // Saturates a phase setting to the range of the current ratio.
  function automatic logic [9:0] clip_phase(input logic [9:0] ph, input logic [3:0] code);
    logic [3:0] c;
    logic [9:0] hi;
    c  = (code > PHASE_CODE_MAX) ? PHASE_CODE_MAX : code;
    hi = 10'((11'h020 << c) - 11'h001);
    if ($signed(ph) > $signed(hi)) return hi;
    if ($signed(ph) < $signed(~hi)) return ~hi;
    return ph;
  endfunction

endpackage

// file: src/acrc_regcheck.sv
// Serial checksum engine over a snapshot of the writable register bits.
// Assumes the caller holds the bit vector in register order, first bit at the top.
`timescale 1ns/1ns
module acrc_regcheck (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  // Control
  input  wire logic                              enable,
  input  wire logic                              poly_sel,
  input  wire logic [acrc_pkg::REGCHECK_BITS-1:0] reg_bits,
  // Result
  output      logic [15:0]                       result_q,
  output      logic                              done_q
);
  typedef enum logic {RC_IDLE, RC_SHIFT} acrc_rc_state_type;
  acrc_rc_state_type                      state_q;
  logic [acrc_pkg::REGCHECK_BITS-1:0]     snap_q;
  logic [7:0]                             idx_q;
  logic [15:0]                            crc_q;
  logic [15:0]                            crc_d;
  logic [15:0]                            poly;

  assign poly  = poly_sel ? acrc_pkg::CRC_POLY_ANSI : acrc_pkg::CRC_POLY_CCITT;
  assign crc_d = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ snap_q[idx_q]) ? poly : 16'h0000);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q  <= RC_IDLE;
      snap_q   <= '0;
      idx_q    <= 8'h00;
      crc_q    <= acrc_pkg::CRC_SEED;
      result_q <= acrc_pkg::REGCHECK_RESET;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        RC_IDLE: begin
          if (enable) begin
            snap_q  <= reg_bits;
            crc_q   <= acrc_pkg::CRC_SEED;
            idx_q   <= 8'(acrc_pkg::REGCHECK_BITS - 1);
            state_q <= RC_SHIFT;
          end
        end
        RC_SHIFT: begin
          crc_q <= crc_d;
          idx_q <= idx_q - 8'h01;
          if (idx_q == 8'h00) begin
            result_q <= crc_d;
            done_q   <= 1'b1;
            state_q  <= RC_IDLE;
          end
        end
        default: state_q <= RC_IDLE;
      endcase
    end
  end
endmodule // acrc_regcheck

// file: src/acrc_top.sv
// Top of the calibration back end: APB registers, phase timing, ready, temperature mode.
// Assumes raw filter outputs on the system clock, which is also the modulator clock.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - Phase range follows ratio, capped at 511
// - Out-of-range phase saturates to nearest limit
// - Phase is ten-bit signed modulator cycles
// - Phase settings move the ready timing
// - Signed offset subtracted from each result
// - Unsigned gain multiplies, 800000h is unity
// - Correction always on, reset gives identity
// - Checksum covers all writable register bits
// - Checksum polynomial chosen by mode bit
// - Sixteen-bit checksum held in readable register
// - Checksum starts from FFFFh
// - Checksum change raises the changed flag
// - Status read or null response clears flag
// - Temp enable picks pins or temperature
// - Source select picks internal or external sensor
// - Third channel updates every 32nd ready
// - Fresh temperature result sets its flag
// - Third channel modulator clock divided by 32
module acrc_top (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  // Filter outputs
  input  wire logic [2:0][23:0]  raw_sample,
  // Converter controls
  output      logic              conversion_ready_n,
  output      logic              third_channel_mod_tick,
  output      logic              third_channel_temp_route,
  output      logic              third_channel_external,
  output      logic              chop_enable
);
  // ****************************************
  // Registers
  // ****************************************
  acrc_pkg::acrc_mode_type         mode_q;
  acrc_pkg::acrc_config_type       cfg_q;
  logic [2:0][9:0]                 phase_q;
  logic [2:0][23:0]                offset_q;
  logic [2:0][23:0]                gain_q;
  logic [2:0][23:0]                result_q;
  logic [15:0]                     regcheck_q;
  logic                            regmap_chg_q;
  logic                            third_new_q;
  logic [31:0]                     prdata_q;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [13:0]                     mod_count_q;
  logic [2:0]                      pend_q;
  logic [4:0]                      fall_count_q;
  logic [4:0]                      div_q;
  logic                            ready_n_q;
  logic                            tick_q;
  logic                            route_q;
  logic                            ext_q;
  logic                            chop_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        setup    = psel & ~penable;
  wire        done     = psel & penable & pready_q;
  wire        wr       = done & pwrite;
  wire        rd       = done & ~pwrite;
  wire        stat_rd  = rd & ((paddr == acrc_pkg::ADDR_STATUS) |
                               (paddr == acrc_pkg::ADDR_NULL_RESP));
  wire [31:0] status_w = 32'({~ready_n_q, third_new_q, regmap_chg_q});
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      acrc_pkg::ADDR_STATUS, acrc_pkg::ADDR_NULL_RESP: rd_data = status_w;
      acrc_pkg::ADDR_MODE:     rd_data = 32'(mode_q);
      acrc_pkg::ADDR_CONFIG:   rd_data = 32'(cfg_q);
      acrc_pkg::ADDR_REGCHECK: rd_data = 32'(regcheck_q);
      default: begin
        rd_hit = 1'b0;
        for (int c = 0; c < 3; c++) begin
          if (paddr == 8'(acrc_pkg::ADDR_PHASE0 + acrc_pkg::ADDR_STEP * c)) begin
            rd_data = 32'(phase_q[c]);
            rd_hit  = 1'b1;
          end
          if (paddr == 8'(acrc_pkg::ADDR_OFFSET0 + acrc_pkg::ADDR_STEP * c)) begin
            rd_data = 32'(offset_q[c]);
            rd_hit  = 1'b1;
          end
          if (paddr == 8'(acrc_pkg::ADDR_GAIN0 + acrc_pkg::ADDR_STEP * c)) begin
            rd_data = 32'(gain_q[c]);
            rd_hit  = 1'b1;
          end
          if (paddr == 8'(acrc_pkg::ADDR_RESULT0 + acrc_pkg::ADDR_STEP * c)) begin
            rd_data = 32'(result_q[c]);
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  // No wait state: data and ready are registered in the setup cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      prdata_q  <= setup ? rd_data : prdata_q;
      pslverr_q <= setup & ~rd_hit;
    end
  end

  // ****************************************
  // Configuration writes
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q   <= acrc_pkg::MODE_RESET;
      cfg_q    <= acrc_pkg::CONFIG_RESET;
      phase_q  <= {3{acrc_pkg::PHASE_RESET}};
      offset_q <= {3{acrc_pkg::OFFSET_RESET}};
      gain_q   <= {3{acrc_pkg::GAIN_RESET}};
    end else if (wr) begin
      if (paddr == acrc_pkg::ADDR_MODE) mode_q <= pwdata[1:0];
      if (paddr == acrc_pkg::ADDR_CONFIG) cfg_q <= pwdata[6:0];
      for (int c = 0; c < 3; c++) begin
        if (paddr == 8'(acrc_pkg::ADDR_PHASE0 + acrc_pkg::ADDR_STEP * c)) begin
          phase_q[c] <= pwdata[9:0];
        end
        if (paddr == 8'(acrc_pkg::ADDR_OFFSET0 + acrc_pkg::ADDR_STEP * c)) begin
          offset_q[c] <= pwdata[23:0];
        end
        if (paddr == 8'(acrc_pkg::ADDR_GAIN0 + acrc_pkg::ADDR_STEP * c)) begin
          gain_q[c] <= pwdata[23:0];
        end
      end
    end
  end

  // ****************************************
  // Sample timing and calibration
  // ****************************************
  wire [13:0] mask     = acrc_pkg::osr_mask(cfg_q.osr_code);
  wire        temp_slot = fall_count_q == acrc_pkg::TEMP_LAST;
  logic [2:0][9:0] clipped;
  logic [2:0]      cap;
  acrc_pkg::acrc_sample_type [2:0] cal_in;
  acrc_pkg::acrc_sample_type [2:0] cal_out;

  for (genvar c = 0; c < 3; c++) begin : g_chan
    assign clipped[c] = acrc_pkg::clip_phase(phase_q[c], cfg_q.osr_code);
    assign cap[c]     = mod_count_q == ({{4{clipped[c][9]}}, clipped[c]} & mask);
    assign cal_in[c].valid = cap[c] & ((c != 2) | ~cfg_q.temp_en | temp_slot);
    assign cal_in[c].data  = raw_sample[c];
    acrc_calib u_calib (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .offset_coefficient (offset_q[c]),
      .gain_coefficient   (gain_q[c]),
      .in_sample          (cal_in[c]),
      .out_q              (cal_out[c])
    );
  end

  wire [2:0] pend_set = {cal_out[2].valid | (cap[2] & ~cal_in[2].valid),
                         cal_out[1].valid, cal_out[0].valid};
  wire       all_in   = &pend_q;
  wire       res_rd   = rd & (paddr >= acrc_pkg::ADDR_RESULT0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mod_count_q  <= 14'h0000;
      pend_q       <= 3'h0;
      fall_count_q <= 5'h00;
      ready_n_q    <= 1'b1;
      result_q     <= '0;
    end else begin
      mod_count_q <= (mod_count_q >= mask) ? 14'h0000 : mod_count_q + 14'h0001;
      pend_q      <= all_in ? pend_set : (pend_q | pend_set);
      if (all_in) begin
        ready_n_q    <= 1'b0;
        fall_count_q <= fall_count_q + 5'h01;
      end else if (res_rd | (|cap)) begin
        ready_n_q <= 1'b1;
      end
      for (int c = 0; c < 3; c++) begin
        if (cal_out[c].valid) result_q[c] <= cal_out[c].data;
      end
    end
  end

  // ****************************************
  // Register check and status flags
  // ****************************************
  logic [15:0] crc_result;
  logic        crc_done;
  wire         crc_changed = crc_done & (crc_result != regcheck_q);

  acrc_regcheck u_regcheck (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .enable   (mode_q.regcheck_en),
    .poly_sel (mode_q.crc_type),
    .reg_bits ({mode_q, cfg_q, phase_q, offset_q, gain_q}),
    .result_q (crc_result),
    .done_q   (crc_done)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regcheck_q   <= acrc_pkg::REGCHECK_RESET;
      regmap_chg_q <= 1'b0;
      third_new_q  <= 1'b0;
    end else begin
      if (crc_done) regcheck_q <= crc_result;
      regmap_chg_q <= crc_changed | (regmap_chg_q & ~stat_rd);
      third_new_q  <= (cal_out[2].valid & cfg_q.temp_en) | (third_new_q & ~stat_rd);
    end
  end

  // ****************************************
  // Third channel modulator control
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q   <= 5'h00;
      tick_q  <= 1'b0;
      route_q <= 1'b0;
      ext_q   <= 1'b0;
      chop_q  <= 1'b0;
    end else begin
      div_q   <= div_q + 5'h01;
      tick_q  <= ~cfg_q.temp_en | (div_q == acrc_pkg::TEMP_LAST);
      route_q <= cfg_q.temp_en & ~cfg_q.temp_sel;
      ext_q   <= cfg_q.temp_en & cfg_q.temp_sel;
      chop_q  <= cfg_q.chop;
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign conversion_ready_n       = ready_n_q;
  assign third_channel_mod_tick   = tick_q;
  assign third_channel_temp_route = route_q;
  assign third_channel_external   = ext_q;
  assign chop_enable              = chop_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_phase_clip_high: assert property ((cfg_q.osr_code >= acrc_pkg::PHASE_CODE_MAX) |->
    (clipped[0] == phase_q[0])) else $error("phase clipped at full range");
  a_phase_clip_low: assert property ((cfg_q.osr_code == 4'h0 &&
    $signed(phase_q[1]) < -10'sd32) |-> (clipped[1] == 10'h3e0))
    else $error("phase not clipped low");
  a_ready_falls: assert property (all_in |=> !conversion_ready_n)
    else $error("ready did not fall");
  a_unity_cal: assert property ((cal_in[0].valid && offset_q[0] == 24'h000000 &&
    gain_q[0] == 24'h800000) |=> (cal_out[0].data == $past(raw_sample[0])))
    else $error("default calibration not identity");
  a_regcheck_store: assert property (crc_done |=> (regcheck_q == $past(crc_result)))
    else $error("checksum not stored");
  a_change_flag: assert property (crc_changed |=> regmap_chg_q)
    else $error("change flag not set");
  a_flag_clear: assert property ((stat_rd && !crc_changed) |=> !regmap_chg_q)
    else $error("change flag not cleared");
  a_temp_rate: assert property ((cal_in[2].valid && cfg_q.temp_en) |-> temp_slot)
    else $error("temperature sample off slot");
  a_temp_flag: assert property ((cal_out[2].valid && cfg_q.temp_en) |=> third_new_q)
    else $error("temperature flag not set");
  a_temp_divide: assert property ((tick_q && cfg_q.temp_en && $past(cfg_q.temp_en)) |=>
    (!tick_q || !cfg_q.temp_en) [*8]) else $error("divided tick too fast");

  c_ready_fall: cover property ($fell(conversion_ready_n));
  c_regmap_change: cover property (crc_changed);
  c_temp_result: cover property (cal_out[2].valid && cfg_q.temp_en);
endmodule // acrc_top
